// file: common/dual_port_block_ram_regs.svh
// Register offsets, field positions and reset values of the dual-port block memory.
`ifndef DUAL_PORT_BLOCK_RAM_REGS_SVH
`define DUAL_PORT_BLOCK_RAM_REGS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define CTRL_OFS        8'h00
`define SRVAL_A_OFS     8'h04
`define SRVAL_B_OFS     8'h08
`define SRVAL_PAR_OFS   8'h0C
`define STATUS_OFS      8'h10
`define WRCNT_OFS       8'h14

// ****************************************************************
// Field positions
// ****************************************************************
`define CTRL_A_LSB      0
`define CTRL_B_LSB      8
`define PAR_A_LSB       0
`define PAR_B_LSB       4
`define STATUS_CLASH    0
`define STATUS_DUAL     1
`define WRCNT_B_LSB     16

// ****************************************************************
// Reset values and AHB-Lite transfer encodings
// ****************************************************************
`define CTRL_RST        5'h00
`define SRVAL_RST       32'h00000000
`define SRVAL_PAR_RST   4'h0
`define HTRANS_NONSEQ   2'h2
`define HSIZE_WORD      3'h2

`endif

// file: common/block_ram_pkg.sv
// Types shared by the dual-port block memory files.
package block_ram_pkg;

    // ****************************************************************
    // Write modes and port configuration
    // ****************************************************************
    typedef enum logic [1:0] {
        WR_FIRST  = 2'h0,
        RD_FIRST  = 2'h1,
        NO_CHANGE = 2'h3
    } wr_mode_e;

    typedef struct packed {
        wr_mode_e mode;
        logic     invSsr;
        logic     invWe;
        logic     invEn;
    } port_cfg_s;

endpackage

// file: core/block_store.sv
// Shared bit-addressed storage array with two mixed-width access ports.
`timescale 1ns/1ps
`default_nettype none

module block_store #(
    parameter int          DWA       = 8,
    parameter int          PWA       = 1,
    parameter int          AWA       = 11,
    parameter int          DWB       = 16,
    parameter int          PWB       = 2,
    parameter int          AWB       = 10,
    parameter logic [31:0] INIT_DATA = 32'h00000000,
    parameter logic [3:0]  INIT_PAR  = 4'h0,
    localparam int         PXA       = (PWA > 0) ? PWA : 1,
    localparam int         PXB       = (PWB > 0) ? PWB : 1
) (
    // Clock.
    input  wire logic           clk,
    // Port A.
    input  wire logic           writeA,
    input  wire logic [AWA-1:0] addrA,
    input  wire logic [DWA-1:0] dataA,
    input  wire logic [PXA-1:0] parA,
    output logic      [DWA-1:0] oldDataA,
    output logic      [PXA-1:0] oldParA,
    // Port B.
    input  wire logic           writeB,
    input  wire logic [AWB-1:0] addrB,
    input  wire logic [DWB-1:0] dataB,
    input  wire logic [PXB-1:0] parB,
    output logic      [DWB-1:0] oldDataB,
    output logic      [PXB-1:0] oldParB,
    // Both ports write the same physical word.
    output logic                wordClash
);

    logic        dataMem [0:16383];
    logic        parMem  [0:2047];
    logic [13:0] baseA;
    logic [13:0] baseB;
    logic [10:0] pbaseA;
    logic [10:0] pbaseB;

    // ****************************************************************
    // Address mapping
    // ****************************************************************
    assign baseA     = 14'(int'(addrA) * DWA);
    assign baseB     = 14'(int'(addrB) * DWB);
    assign pbaseA    = baseA[13:3];
    assign pbaseB    = baseB[13:3];
    assign wordClash = writeA & writeB & (baseA[13:5] == baseB[13:5]);

    initial begin
        for (int k = 0; k < 16384; k++) begin
            dataMem[k] = INIT_DATA[k % 32];
        end
        for (int k = 0; k < 2048; k++) begin
            parMem[k] = INIT_PAR[k % 4];
        end
    end

    // ****************************************************************
    // Reads of the stored contents
    // ****************************************************************
    always_comb begin
        oldDataA = '0;
        oldParA  = '0;
        oldDataB = '0;
        oldParB  = '0;
        for (int i = 0; i < DWA; i++) begin
            oldDataA[i] = dataMem[baseA + 14'(i)];
        end
        for (int i = 0; i < PWA; i++) begin
            oldParA[i] = parMem[pbaseA + 11'(i)];
        end
        for (int i = 0; i < DWB; i++) begin
            oldDataB[i] = dataMem[baseB + 14'(i)];
        end
        for (int i = 0; i < PWB; i++) begin
            oldParB[i] = parMem[pbaseB + 11'(i)];
        end
    end

    // ****************************************************************
    // Writes; port B is applied last and wins on a shared bit
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (writeA) begin
            for (int i = 0; i < DWA; i++) begin
                dataMem[baseA + 14'(i)] <= dataA[i];
            end
            for (int i = 0; i < PWA; i++) begin
                parMem[pbaseA + 11'(i)] <= parA[i];
            end
        end
        if (writeB) begin
            for (int i = 0; i < DWB; i++) begin
                dataMem[baseB + 14'(i)] <= dataB[i];
            end
            for (int i = 0; i < PWB; i++) begin
                parMem[pbaseB + 11'(i)] <= parB[i];
            end
        end
    end

endmodule

`default_nettype wire

// file: core/mem_port.sv
// Control decode and output register of one memory port.
`timescale 1ns/1ps
`default_nettype none

module mem_port #(
    parameter int           DW        = 8,
    parameter int           PX        = 1,
    parameter bit           ACTIVE    = 1'b1,
    parameter logic [31:0]  RESET_OUT = 32'h00000000,
    parameter logic [3:0]   RESET_PAR = 4'h0
) (
    // Clock and reset.
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    // Configuration.
    input  wire block_ram_pkg::port_cfg_s  cfg,
    input  wire logic [DW-1:0]             srvalData,
    input  wire logic [PX-1:0]             srvalPar,
    // User controls and data.
    input  wire logic                      enable,
    input  wire logic                      writeEnable,
    input  wire logic                      outputSetReset,
    input  wire logic [DW-1:0]             wrData,
    input  wire logic [PX-1:0]             wrPar,
    input  wire logic [DW-1:0]             oldData,
    input  wire logic [PX-1:0]             oldPar,
    // Results.
    output logic                           writeStrobe,
    output logic      [DW-1:0]             readData,
    output logic      [PX-1:0]             readPar
);

    logic          effEn;
    logic          effWe;
    logic          effSsr;
    logic [DW-1:0] data_d;
    logic [DW-1:0] data_q;
    logic [PX-1:0] par_d;
    logic [PX-1:0] par_q;

    // ****************************************************************
    // Control polarity and output selection
    // ****************************************************************
    always_comb begin
        effEn       = ACTIVE & (enable ^ cfg.invEn);
        effWe       = writeEnable ^ cfg.invWe;
        effSsr      = outputSetReset ^ cfg.invSsr;
        writeStrobe = effEn & effWe;
        data_d      = data_q;
        par_d       = par_q;
        if (effEn) begin
            if (effSsr) begin
                data_d = srvalData;
                par_d  = srvalPar;
            end else begin
                unique case (cfg.mode)
                    block_ram_pkg::RD_FIRST: begin
                        data_d = oldData;
                        par_d  = oldPar;
                    end
                    block_ram_pkg::NO_CHANGE: begin
                        if (!effWe) begin
                            data_d = oldData;
                            par_d  = oldPar;
                        end
                    end
                    default: begin
                        data_d = effWe ? wrData : oldData;
                        par_d  = effWe ? wrPar : oldPar;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            data_q <= RESET_OUT[DW-1:0];
            par_q  <= RESET_PAR[PX-1:0];
        end else begin
            data_q <= data_d;
            par_q  <= par_d;
        end
    end

    assign readData = data_q;
    assign readPar  = par_q;

endmodule

`default_nettype wire

// file: core/dual_port_block_ram.sv
// Dual-port mixed-width block memory with an AHB-Lite configuration slave.
// ****************************************************************
// What this block does
// - Two identical ports, each with own controls, address and data, work independently.
// - Storage holds 18,432 bits with parity, 16,384 bits of data alone.
// - Each port width is chosen alone from 1, 2, 4, 9, 18 or 36.
// - Address width is 14 minus log2 of the data width without parity.
// - Port depth is two to the address width, 16,384 down to 512.
// - Widths 9, 18 and 36 carry 1, 2, 4 parity bits on own bus.
// - Widths 4, 2 and 1 ignore parity in; their parity out is zero except after set/reset loads its parity bit.
// - Narrow words written on one port read back combined on a wider port.
// - A wide word read on a narrower port returns consecutive narrow pieces.
// - Every parity bit stays attached to its own data byte across widths.
// - Single-port use keeps port A only; dual-port use enables both ports.
// - Initial contents, output default, width and write mode are configurable.
// - Data written on either port reads back on the same and opposite port.
// - A port writes data and parity only when enable and write enable hold.
// - Write enable, enable and set/reset are active high, each invertible.
// - The chosen width applies to the write path and read path alike.
// ****************************************************************
`timescale 1ns/1ps
`default_nettype none
`include "dual_port_block_ram_regs.svh"

module dual_port_block_ram #(
    parameter int          WIDTH_A   = 9,
    parameter int          WIDTH_B   = 18,
    parameter bit          DUAL_PORT = 1'b1,
    parameter logic [31:0] INIT_DATA = 32'h00000000,
    parameter logic [3:0]  INIT_PAR  = 4'h0,
    localparam int         DWA       = (WIDTH_A >= 9) ? (WIDTH_A / 9) * 8 : WIDTH_A,
    localparam int         PWA       = WIDTH_A / 9,
    localparam int         AWA       = 14 - $clog2(DWA),
    localparam int         PXA       = (PWA > 0) ? PWA : 1,
    localparam int         DWB       = (WIDTH_B >= 9) ? (WIDTH_B / 9) * 8 : WIDTH_B,
    localparam int         PWB       = WIDTH_B / 9,
    localparam int         AWB       = 14 - $clog2(DWB),
    localparam int         PXB       = (PWB > 0) ? PWB : 1
) (
    // Clock and reset.
    input  wire logic           clk,
    input  wire logic           rst_n,
    // AHB-Lite slave.
    input  wire logic           hsel,
    input  wire logic [31:0]    haddr,
    input  wire logic [1:0]     htrans,
    input  wire logic           hwrite,
    input  wire logic [2:0]     hsize,
    input  wire logic [31:0]    hwdata,
    input  wire logic           hready,
    output logic                hreadyout,
    output logic                hresp,
    output logic      [31:0]    hrdata,
    // Memory port A.
    input  wire logic           enableA,
    input  wire logic           writeEnableA,
    input  wire logic           outputSetResetA,
    input  wire logic [AWA-1:0] addrA,
    input  wire logic [DWA-1:0] writeDataInA,
    input  wire logic [PXA-1:0] parityInA,
    output logic      [DWA-1:0] readDataA,
    output logic      [PXA-1:0] parityOutA,
    // Memory port B.
    input  wire logic           enableB,
    input  wire logic           writeEnableB,
    input  wire logic           outputSetResetB,
    input  wire logic [AWB-1:0] addrB,
    input  wire logic [DWB-1:0] writeDataInB,
    input  wire logic [PXB-1:0] parityInB,
    output logic      [DWB-1:0] readDataB,
    output logic      [PXB-1:0] parityOutB
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    block_ram_pkg::port_cfg_s cfgA_d;
    block_ram_pkg::port_cfg_s cfgA_q;
    block_ram_pkg::port_cfg_s cfgB_d;
    block_ram_pkg::port_cfg_s cfgB_q;
    logic [31:0]              srvalA_d;
    logic [31:0]              srvalA_q;
    logic [31:0]              srvalB_d;
    logic [31:0]              srvalB_q;
    logic [7:0]               srvalPar_d;
    logic [7:0]               srvalPar_q;
    logic                     clash_d;
    logic                     clash_q;
    logic [15:0]              cntA_d;
    logic [15:0]              cntA_q;
    logic [15:0]              cntB_d;
    logic [15:0]              cntB_q;
    logic                     wrPend_d;
    logic                     wrPend_q;
    logic [7:0]               wrAddr_d;
    logic [7:0]               wrAddr_q;
    logic [31:0]              hrdata_d;
    logic [31:0]              hrdata_q;
    logic                     accept;
    logic                     strobeA;
    logic                     strobeB;
    logic                     wordClash;
    logic [DWA-1:0]           oldDataA;
    logic [PXA-1:0]           oldParA;
    logic [DWB-1:0]           oldDataB;
    logic [PXB-1:0]           oldParB;
    logic [PXA-1:0]           parInA;
    logic [PXB-1:0]           parInB;

    // ****************************************************************
    // Parity inputs of narrow ports are ignored
    // ****************************************************************
    assign parInA = (PWA > 0) ? parityInA : '0;
    assign parInB = (PWB > 0) ? parityInB : '0;

    // ****************************************************************
    // Shared storage
    // ****************************************************************
    block_store #(
        .DWA       (DWA),
        .PWA       (PWA),
        .AWA       (AWA),
        .DWB       (DWB),
        .PWB       (PWB),
        .AWB       (AWB),
        .INIT_DATA (INIT_DATA),
        .INIT_PAR  (INIT_PAR)
    ) u_store (
        .clk       (clk),
        .writeA    (strobeA),
        .addrA     (addrA),
        .dataA     (writeDataInA),
        .parA      (parInA),
        .oldDataA  (oldDataA),
        .oldParA   (oldParA),
        .writeB    (strobeB),
        .addrB     (addrB),
        .dataB     (writeDataInB),
        .parB      (parInB),
        .oldDataB  (oldDataB),
        .oldParB   (oldParB),
        .wordClash (wordClash)
    );

    // ****************************************************************
    // Port A
    // ****************************************************************
    mem_port #(
        .DW             (DWA),
        .PX             (PXA),
        .ACTIVE         (1'b1),
        .RESET_OUT      (`SRVAL_RST),
        .RESET_PAR      (`SRVAL_PAR_RST)
    ) u_portA (
        .clk            (clk),
        .rst_n          (rst_n),
        .cfg            (cfgA_q),
        .srvalData      (srvalA_q[DWA-1:0]),
        .srvalPar       (srvalPar_q[`PAR_A_LSB +: PXA]),
        .enable         (enableA),
        .writeEnable    (writeEnableA),
        .outputSetReset (outputSetResetA),
        .wrData         (writeDataInA),
        .wrPar          (parInA),
        .oldData        (oldDataA),
        .oldPar         (oldParA),
        .writeStrobe    (strobeA),
        .readData       (readDataA),
        .readPar        (parityOutA)
    );

    // ****************************************************************
    // Port B, held idle in single-port use
    // ****************************************************************
    mem_port #(
        .DW             (DWB),
        .PX             (PXB),
        .ACTIVE         (DUAL_PORT),
        .RESET_OUT      (`SRVAL_RST),
        .RESET_PAR      (`SRVAL_PAR_RST)
    ) u_portB (
        .clk            (clk),
        .rst_n          (rst_n),
        .cfg            (cfgB_q),
        .srvalData      (srvalB_q[DWB-1:0]),
        .srvalPar       (srvalPar_q[`PAR_B_LSB +: PXB]),
        .enable         (enableB),
        .writeEnable    (writeEnableB),
        .outputSetReset (outputSetResetB),
        .wrData         (writeDataInB),
        .wrPar          (parInB),
        .oldData        (oldDataB),
        .oldPar         (oldParB),
        .writeStrobe    (strobeB),
        .readData       (readDataB),
        .readPar        (parityOutB)
    );

    // ****************************************************************
    // AHB-Lite register file
    // ****************************************************************
    assign accept = hsel & hready & (htrans == `HTRANS_NONSEQ);

    always_comb begin
        cfgA_d     = cfgA_q;
        cfgB_d     = cfgB_q;
        srvalA_d   = srvalA_q;
        srvalB_d   = srvalB_q;
        srvalPar_d = srvalPar_q;
        clash_d    = clash_q;
        cntA_d     = cntA_q;
        cntB_d     = cntB_q;
        wrPend_d   = wrPend_q;
        wrAddr_d   = wrAddr_q;
        hrdata_d   = hrdata_q;
        if (wrPend_q) begin
            unique case (wrAddr_q)
                `CTRL_OFS: begin
                    cfgA_d = block_ram_pkg::port_cfg_s'(hwdata[`CTRL_A_LSB +: 5]);
                    cfgB_d = block_ram_pkg::port_cfg_s'(hwdata[`CTRL_B_LSB +: 5]);
                end
                `SRVAL_A_OFS: srvalA_d = hwdata;
                `SRVAL_B_OFS: srvalB_d = hwdata;
                `SRVAL_PAR_OFS: srvalPar_d = hwdata[7:0];
                `STATUS_OFS: begin
                    if (hwdata[`STATUS_CLASH]) begin
                        clash_d = 1'b0;
                    end
                end
                `WRCNT_OFS: begin
                    cntA_d = 16'h0000;
                    cntB_d = 16'h0000;
                end
                default: ;
            endcase
        end
        if (wordClash) begin
            clash_d = 1'b1;
        end
        if (strobeA) begin
            cntA_d = cntA_d + 16'h0001;
        end
        if (strobeB) begin
            cntB_d = cntB_d + 16'h0001;
        end
        if (hready) begin
            wrPend_d = accept & hwrite & (hsize == `HSIZE_WORD);
            wrAddr_d = haddr[7:0];
        end
        if (accept & !hwrite) begin
            unique case (haddr[7:0])
                `CTRL_OFS: hrdata_d = {19'h00000, cfgB_d, 3'h0, cfgA_d};
                `SRVAL_A_OFS: hrdata_d = srvalA_d;
                `SRVAL_B_OFS: hrdata_d = srvalB_d;
                `SRVAL_PAR_OFS: hrdata_d = {24'h000000, srvalPar_d};
                `STATUS_OFS: hrdata_d = {30'h00000000, DUAL_PORT, clash_d};
                `WRCNT_OFS: hrdata_d = {cntB_d, cntA_d};
                default: hrdata_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfgA_q     <= block_ram_pkg::port_cfg_s'(`CTRL_RST);
            cfgB_q     <= block_ram_pkg::port_cfg_s'(`CTRL_RST);
            srvalA_q   <= `SRVAL_RST;
            srvalB_q   <= `SRVAL_RST;
            srvalPar_q <= {`SRVAL_PAR_RST, `SRVAL_PAR_RST};
            clash_q    <= 1'b0;
            cntA_q     <= 16'h0000;
            cntB_q     <= 16'h0000;
            wrPend_q   <= 1'b0;
            wrAddr_q   <= 8'h00;
            hrdata_q   <= 32'h00000000;
        end else begin
            cfgA_q     <= cfgA_d;
            cfgB_q     <= cfgB_d;
            srvalA_q   <= srvalA_d;
            srvalB_q   <= srvalB_d;
            srvalPar_q <= srvalPar_d;
            clash_q    <= clash_d;
            cntA_q     <= cntA_d;
            cntB_q     <= cntB_d;
            wrPend_q   <= wrPend_d;
            wrAddr_q   <= wrAddr_d;
            hrdata_q   <= hrdata_d;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_q;

endmodule

`default_nettype wire

// file: verification/block_ram_sva.sv
// Concurrent checks on the block memory ports and bus answer.
`timescale 1ns/1ps
`default_nettype none
module block_ram_sva #(
    parameter int DWA = 8, PXA = 1, AWA = 11, DWB = 16, PXB = 2, AWB = 10
) (
    // Clock, reset and bus answer.
    input wire logic           clk,
    input wire logic           rst_n,
    input wire logic           hreadyout,
    input wire logic           hresp,
    // Port A.
    input wire logic           enableA,
    input wire logic           writeEnableA,
    input wire logic           outputSetResetA,
    input wire logic [AWA-1:0] addrA,
    input wire logic [DWA-1:0] writeDataInA,
    input wire logic [PXA-1:0] parityInA,
    input wire logic [DWA-1:0] readDataA,
    input wire logic [PXA-1:0] parityOutA,
    // Port B.
    input wire logic           enableB,
    input wire logic           writeEnableB,
    input wire logic           outputSetResetB,
    input wire logic [AWB-1:0] addrB,
    input wire logic [DWB-1:0] writeDataInB,
    input wire logic [PXB-1:0] parityInB,
    input wire logic [DWB-1:0] readDataB,
    input wire logic [PXB-1:0] parityOutB
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_bus; hreadyout && !hresp; endproperty
    a_bus: assert property (p_bus) else $error("bus answer");
    property p_wf_a; enableA && writeEnableA && !outputSetResetA
        |=> {parityOutA, readDataA} == $past({parityInA, writeDataInA}); endproperty
    a_wf_a: assert property (p_wf_a) else $error("A write data");
    property p_wf_b; enableB && writeEnableB && !outputSetResetB
        |=> {parityOutB, readDataB} == $past({parityInB, writeDataInB}); endproperty
    a_wf_b: assert property (p_wf_b) else $error("B write data");
    property p_hold_a; !enableA |=> $stable({parityOutA, readDataA}); endproperty
    a_hold_a: assert property (p_hold_a) else $error("A output moved");
    property p_hold_b; !enableB |=> $stable({parityOutB, readDataB}); endproperty
    a_hold_b: assert property (p_hold_b) else $error("B output moved");
    property p_a2b; enableA && writeEnableA && !(enableB && writeEnableB) ##1 enableB
        && !writeEnableB && !outputSetResetB && addrB == $past(addrA[AWA-1:1])
        |=> {parityOutB[$past(addrA[0], 2)], readDataB[8 * $past(addrA[0], 2) +: 8]}
        == $past({parityInA, writeDataInA}, 2); endproperty
    a_a2b: assert property (p_a2b) else $error("A to B");
    property p_b2a; enableB && writeEnableB ##1 enableA && !writeEnableA && !outputSetResetA
        && addrA[AWA-1:1] == $past(addrB) |=> {parityOutA, readDataA} == ($past(addrA[0])
        ? $past({parityInB[1], writeDataInB[15:8]}, 2)
        : $past({parityInB[0], writeDataInB[7:0]}, 2)); endproperty
    a_b2a: assert property (p_b2a) else $error("B to A");
    property p_rr_b; enableB && !writeEnableB && !outputSetResetB && !(enableA && writeEnableA)
        ##1 enableB && !writeEnableB && !outputSetResetB && $stable(addrB)
        |=> $stable({parityOutB, readDataB}); endproperty
    a_rr_b: assert property (p_rr_b) else $error("reread moved");
endmodule
bind dual_port_block_ram block_ram_sva #(.DWA(DWA), .PXA(PXA), .AWA(AWA), .DWB(DWB),
    .PXB(PXB), .AWB(AWB)) sva_u (.*);
`default_nettype wire

// file: verification/port_user.sv
// Random user logic driving one memory port.
`timescale 1ns/1ps
`default_nettype none
module port_user #(parameter int AW = 11, DW = 8, PX = 1, SEED = 32'hD43E) (
    // Clock and mode.
    input  wire logic clk,
    input  wire logic run,
    input  wire logic narrow,
    // Port drive.
    output logic          en,
    output logic          we,
    output logic          output_set_reset,
    output logic [AW-1:0] addr,
    output logic [DW-1:0] data,
    output logic [PX-1:0] par
);
    int seed = SEED + (DW >> 4);
    int r;
    always @(posedge clk) begin
        r = $random(seed);
        en <= run & (r[0] | r[1]);
        we <= r[2];
        output_set_reset <= r[7:4] == 4'h0;
        addr <= narrow ? AW'(r[10:8]) : AW'(r >>> 11);
        data <= DW'($random(seed));
        par <= PX'(r[31:28]);
    end
endmodule
`default_nettype wire

// file: verification/dual_port_block_ram_tb.sv
// Self-checking bench for the dual-port block memory.
`timescale 1ns/1ps
`default_nettype none
`include "dual_port_block_ram_regs.svh"
module dual_port_block_ram_tb;
    logic        clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, run = 1'b0, narrow = 1'b1;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
    logic [1:0]  htrans = '0;
    logic [2:0]  hsize = `HSIZE_WORD;
    wire logic   hready, hreadyout, hresp;
    logic        enableA, writeEnableA, outputSetResetA, enableB, writeEnableB, outputSetResetB;
    logic [10:0] addrA, bA, bB;
    logic [9:0]  addrB;
    logic [7:0]  writeDataInA, readDataA, eA = '0;
    logic [15:0] writeDataInB, readDataB, eB = '0, cntA, cntB;
    logic [0:0]  parityInA, parityOutA, epA = '0;
    logic [1:0]  parityInB, parityOutB, epB = '0;
    logic [7:0]  mem [2048];
    logic        mp [2048];
    logic        clash = 1'b0;
    logic [31:0] vals [3] = '{32'h000000A5, 32'h0000BEEF, 32'h00000031};
    logic [31:0] ofs [3] = '{`SRVAL_A_OFS, `SRVAL_B_OFS, `SRVAL_PAR_OFS};
    int          failures = 0, cmpCount = 0;
    assign hready = hreadyout;
    always #2.5 clk = ~clk;
    localparam logic [35:0] INIT = {4'hA, 32'h12345678};
    dual_port_block_ram #(.INIT_DATA(INIT[31:0]), .INIT_PAR(INIT[35:32])) dut_u (.*);
    port_user userA (.clk, .run, .narrow,
        .en(enableA), .we(writeEnableA), .output_set_reset(outputSetResetA), .addr(addrA),
        .data(writeDataInA), .par(parityInA));
    port_user #(.AW(10), .DW(16), .PX(2)) userB (.clk, .run,
        .narrow, .en(enableB), .we(writeEnableB), .output_set_reset(outputSetResetB),
        .addr(addrB), .data(writeDataInB), .par(parityInB));
    task automatic chk(input logic ok, input string m);
        cmpCount++;
        if (ok !== 1'b1) begin
            failures++;
            $display("FAIL %0t %s", $time, m);
        end
    endtask
    task automatic ahb(input logic [31:0] a, input logic w, input logic [31:0] wd);
        @(posedge clk);
        {hsel, haddr, htrans, hwrite} <= {1'b1, a, `HTRANS_NONSEQ, w};
        do @(posedge clk); while (hready !== 1'b1);
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, wd};
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic final_report;
        $display("checks %0d failures %0d", cmpCount, failures);
        if (failures == 0 && cmpCount > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    always @(posedge clk) if (rst_n) begin
        bA = addrA;
        bB = {addrB, 1'b0};
        if (enableA) {epA, eA} = outputSetResetA ? {vals[2][0], vals[0][7:0]} : writeEnableA
            ? {parityInA, writeDataInA} : {mp[bA], mem[bA]};
        if (enableB) {epB, eB} = outputSetResetB ? {vals[2][5:4], vals[1][15:0]}
            : writeEnableB ? {parityInB, writeDataInB} : {mp[bB+1], mp[bB], mem[bB+1], mem[bB]};
        clash |= enableA && writeEnableA && enableB && writeEnableB && bA[10:2] == bB[10:2];
        if (enableA && writeEnableA) {mp[bA], mem[bA], cntA} = {parityInA, writeDataInA, cntA + 16'h1};
        if (enableB && writeEnableB) {mp[bB+1], mp[bB], mem[bB+1], mem[bB], cntB} =
            {parityInB, writeDataInB, cntB + 16'h1};
    end
    always @(negedge clk) if (rst_n) begin
        chk({parityOutA, readDataA} === {epA, eA}, "A output");
        chk({parityOutB, readDataB} === {epB, eB}, "B output");
    end
    initial begin
        #100000;
        failures++;
        final_report;
    end
    initial begin
        for (int i = 0; i < 2048; i++) {mp[i], mem[i]} = {INIT[32 + i % 4], INIT[8 * (i % 4) +: 8]};
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            ahb(ofs[i], 1'b0, '0);
            chk(rd === `SRVAL_RST, "reset value");
            ahb(ofs[i], 1'b1, vals[i]);
            ahb(ofs[i], 1'b0, '0);
            chk(rd === vals[i], "readback");
        end
        ahb(32'h00000018, 1'b0, '0);
        chk(rd === 32'h00000000, "unmapped read");
        ahb(32'(`WRCNT_OFS), 1'b1, '0);
        {cntA, cntB} = '0;
        run <= 1'b1;
        repeat (2000) @(posedge clk);
        narrow <= 1'b0;
        repeat (2000) @(posedge clk);
        run <= 1'b0;
        repeat (3) @(posedge clk);
        ahb(32'(`WRCNT_OFS), 1'b0, '0);
        chk(rd === {cntB, cntA}, "write count");
        ahb(32'(`STATUS_OFS), 1'b0, '0);
        chk(rd === {30'h0, 1'b1, clash}, "status");
        final_report;
    end
endmodule
`default_nettype wire
